// >>> rtl/power_wake_status_ctrl.sv
// Purpose: power states, wake indicator, status flags, countdown timer, rom autoload.
// Assumes: host strobes arrive asynchronously and are synchronised here.
// Notes: writes act on the trailing edge of the write strobe, reads on the leading edge.
module power_wake_status_ctrl import power_wake_pkg::*; #(
	parameter int TICK_CYCLES_P = TICK_CYCLES,
	parameter int PULSE_CYCLES_P = PULSE_CYCLES,
	parameter int ROM_HALF_CYCLES_P = ROM_HALF_CYCLES
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic host_cs_n_in,
	input wire logic host_rd_n_in,
	input wire logic host_wr_n_in,
	input wire logic [4:0] host_addr_in,
	input wire logic [15:0] host_data_in,
	output logic [15:0] host_data_out,
	output logic host_data_oe_n_out,
	input wire logic [2:0] wake_event_in,
	input wire logic loopback_switching_in,
	input wire logic remote_data_valid_in,
	input wire logic [15:0] remote_data_in,
	output logic remote_read_start_out,
	output port_write_s remote_write_out,
	output logic timer_irq_out,
	output mem_write_s mem_write_out,
	output power_enables_s power_enables_out,
	output logic wake_indicator_out,
	output logic wake_indicator_oe_n_out,
	output logic serial_rom_select,
	output logic serial_rom_clock,
	output logic serial_rom_data_io_out,
	output logic serial_rom_data_io_oe_n_out,
	input wire logic serial_rom_data_io_in
);
	localparam int PIN_W = 25;

	// paged offsets need the matching page, the rest ignore it
	function automatic logic reg_hit(input logic [4:0] addr, input logic [1:0] page,
			input logic [4:0] off, input logic [1:0] want);
		if (addr != off) begin
			return 1'b0;
		end
		if (off != OFF_COMMAND && off <= OFF_PAGED_LAST) begin
			return page == want;
		end
		return 1'b1;
	endfunction

	logic [PIN_W-1:0] pin_meta;
	logic [PIN_W-1:0] pin_sync;
	logic cs_n;
	logic rd_n;
	logic wr_n;
	logic [4:0] addr;
	logic [15:0] wdata;
	logic rom_din;
	logic [2:0] strobe_prev;
	logic rd_edge;
	logic wr_edge;
	logic [1:0] page;
	logic [2:0] dma_cmd;
	logic word_width_select;
	logic [15:0] transfer_count;
	logic transfer_done_flag;
	logic read_ready;
	logic [3:0] ready_count;
	logic [1:0] power_state;
	logic [2:0] wake_flags;
	logic wake_seen;
	logic wake_clear;
	logic wake_hold;
	logic [22:0] pulse_count;
	logic [2:0] pin_cfg;
	logic [3:0] rom_pins;
	logic [7:0] byte_order;
	logic timer_enable;
	logic [15:0] preload;
	logic [15:0] periodic_countdown;
	logic [13:0] tick_count;
	logic tick;
	logic load_start;
	logic loader_busy;
	logic loader_sel;
	logic loader_clk;
	logic loader_dout;
	logic loader_drive;
	logic [7:0] status_value;
	logic [15:0] next_rdata;
	logic wake_active;
	logic wake_level;

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			pin_meta <= '1;
			pin_sync <= '1;
		end else begin
			pin_meta <= {host_cs_n_in, host_rd_n_in, host_wr_n_in, host_addr_in,
				host_data_in, serial_rom_data_io_in};
			pin_sync <= pin_meta;
		end
	end

	assign {cs_n, rd_n, wr_n, addr, wdata, rom_din} = pin_sync;

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			strobe_prev <= '1;
		end else begin
			strobe_prev <= {cs_n, rd_n, wr_n};
		end
	end

	assign rd_edge = !cs_n && !rd_n && strobe_prev[1];
	assign wr_edge = !strobe_prev[2] && !strobe_prev[0] && wr_n;

	// command register and data width select
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			page <= PAGE0;
			dma_cmd <= '0;
			word_width_select <= 1'b0;
			byte_order <= '0;
		end else if (wr_edge) begin
			if (reg_hit(addr, page, OFF_COMMAND, PAGE0)) begin
				page <= wdata[CR_PAGE_LSB +: 2];
				dma_cmd <= wdata[CR_CMD_LSB +: 3];
			end
			if (reg_hit(addr, page, OFF_DATA_CONFIG, PAGE0)) begin
				word_width_select <= wdata[0];
			end
			if (reg_hit(addr, page, OFF_BYTE_ORDER, PAGE0)) begin
				byte_order <= wdata[7:0];
			end
		end
	end

	assign remote_read_start_out = wr_edge && reg_hit(addr, page, OFF_COMMAND, PAGE0) &&
		wdata[CR_CMD_LSB +: 3] == CMD_REMOTE_READ;

	// remote byte count and data port
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			transfer_count <= '0;
			transfer_done_flag <= 1'b1;
			remote_write_out <= '0;
		end else begin
			remote_write_out.valid <= 1'b0;
			if (wr_edge && reg_hit(addr, page, OFF_COUNT_LOW, PAGE0)) begin
				transfer_count[7:0] <= wdata[7:0];
				transfer_done_flag <= 1'b0;
			end else if (wr_edge && reg_hit(addr, page, OFF_COUNT_HIGH, PAGE0)) begin
				transfer_count[15:8] <= wdata[7:0];
				transfer_done_flag <= 1'b0;
			end else if ((rd_edge || wr_edge) && (addr == OFF_DATA_PORT ||
					addr == OFF_DATA_PORT_HI)) begin
				if (wr_edge && dma_cmd == CMD_REMOTE_WRITE) begin
					remote_write_out <= '{1'b1, word_width_select ? wdata :
						{8'h00, wdata[7:0]}};
				end
				if (transfer_count <= (word_width_select ? 16'h0002 : 16'h0001)) begin
					transfer_count <= '0;
					transfer_done_flag <= 1'b1;
				end else begin
					transfer_count <= transfer_count - (word_width_select ? 16'h0002 :
						16'h0001);
				end
			end
		end
	end

	// read data becomes ready on valid data, at most the not-ready bound later
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			read_ready <= 1'b1;
			ready_count <= '0;
		end else if (remote_read_start_out) begin
			read_ready <= 1'b0;
			ready_count <= '0;
		end else if (!read_ready) begin
			ready_count <= ready_count + 4'h1;
			if (remote_data_valid_in || ready_count == 4'(READ_READY_CYCLES - 2)) begin
				read_ready <= 1'b1;
			end
		end
	end

	// power state register
	assign wake_seen = |wake_event_in && power_state == POWER_STATE_WAKE_LISTEN;

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			power_state <= POWER_STATE_FULL;
		end else if (wake_seen) begin
			power_state <= POWER_STATE_FULL;
		end else if (wr_edge && reg_hit(addr, page, OFF_HOST_RESUME, PAGE0) &&
				power_state != POWER_STATE_FULL) begin
			power_state <= POWER_STATE_FULL;
		end else if (wr_edge && reg_hit(addr, page, OFF_POWER, PAGE3)) begin
			power_state <= wdata[1:0];
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			power_enables_out <= '1;
		end else begin
			unique case (power_state)
				POWER_STATE_FULL: power_enables_out <= '1;
				POWER_STATE_WAKE_LISTEN: power_enables_out <= '{1'b1, 1'b0, 1'b1, 1'b1};
				default: power_enables_out <= '0;
			endcase
		end
	end

	// wake flags and indicator
	assign wake_clear = wr_edge && (reg_hit(addr, page, OFF_POWER, PAGE3) ||
		(reg_hit(addr, page, OFF_WAKE_STATUS, PAGE3) && |wdata[2:0]));

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			wake_flags <= '0;
		end else begin
			wake_flags <= (wake_flags & ~((wr_edge && reg_hit(addr, page, OFF_POWER, PAGE3)) ?
				3'h7 : (wr_edge && reg_hit(addr, page, OFF_WAKE_STATUS, PAGE3)) ?
				wdata[2:0] : 3'h0)) | (wake_seen ? wake_event_in : 3'h0);
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			wake_hold <= 1'b0;
			pulse_count <= '0;
		end else if (wake_seen) begin
			wake_hold <= 1'b1;
			pulse_count <= 23'(PULSE_CYCLES_P);
		end else if (wake_clear) begin
			wake_hold <= 1'b0;
			pulse_count <= '0;
		end else if (pulse_count != '0) begin
			pulse_count <= pulse_count - 23'h000001;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			pin_cfg <= '0;
			rom_pins <= '0;
		end else if (wr_edge && reg_hit(addr, page, OFF_PIN_CONFIG, PAGE0)) begin
			pin_cfg <= wdata[2:0];
		end else if (wr_edge && reg_hit(addr, page, OFF_ROM_PINS, PAGE0)) begin
			rom_pins <= wdata[3:0];
		end
	end

	assign wake_active = pin_cfg[CFG_PULSE_BIT] ? pulse_count != '0 : wake_hold;
	assign wake_level = wake_active ~^ pin_cfg[CFG_ACTIVE_HIGH_BIT];

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			wake_indicator_out <= 1'b0;
			wake_indicator_oe_n_out <= 1'b1;
		end else if (pin_cfg[CFG_OPEN_DRAIN_BIT]) begin
			wake_indicator_out <= 1'b0;
			wake_indicator_oe_n_out <= wake_level;
		end else begin
			wake_indicator_out <= wake_level;
			wake_indicator_oe_n_out <= 1'b0;
		end
	end

	// countdown timer
	assign tick = timer_enable && tick_count == 14'(TICK_CYCLES_P - 1);

	always_ff @(posedge sys_clk_in) begin
		if (reset_in || !timer_enable || tick) begin
			tick_count <= '0;
		end else begin
			tick_count <= tick_count + 14'h0001;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			timer_enable <= 1'b0;
			preload <= COUNT_RESET;
			periodic_countdown <= COUNT_RESET;
		end else if (wr_edge && reg_hit(addr, page, OFF_TIMER_EN, PAGE3)) begin
			timer_enable <= wdata[0];
		end else if (wr_edge && reg_hit(addr, page, OFF_TIMER_LOW, PAGE3)) begin
			preload[7:0] <= wdata[7:0];
			periodic_countdown[7:0] <= wdata[7:0];
		end else if (wr_edge && reg_hit(addr, page, OFF_TIMER_HIGH, PAGE3)) begin
			preload[15:8] <= wdata[7:0];
			periodic_countdown[15:8] <= wdata[7:0];
		end else if (tick) begin
			if (periodic_countdown == '0) begin
				periodic_countdown <= preload;
			end else begin
				periodic_countdown <= periodic_countdown - 16'h0001;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			timer_irq_out <= 1'b0;
		end else if (tick && periodic_countdown == '0) begin
			timer_irq_out <= 1'b1;
		end else if (rd_edge && reg_hit(addr, page, OFF_INT_STATUS, PAGE0)) begin
			timer_irq_out <= 1'b0;
		end
	end

	// rom autoload after reset and on request
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			load_start <= 1'b1;
		end else begin
			load_start <= wr_edge && reg_hit(addr, page, OFF_RELOAD, PAGE3) && wdata[0];
		end
	end

	serial_rom_loader #(
		.HALF_CYCLES_P(ROM_HALF_CYCLES_P),
		.WORDS_P(ROM_WORDS)
	) loader (
		.sys_clk_in(sys_clk_in),
		.reset_in(reset_in),
		.start_in(load_start),
		.rom_data_in(rom_din),
		.busy_out(loader_busy),
		.rom_select_out(loader_sel),
		.rom_clock_out(loader_clk),
		.rom_data_out(loader_dout),
		.rom_drive_out(loader_drive),
		.mem_write_out(mem_write_out)
	);

	assign serial_rom_select = loader_busy ? loader_sel : rom_pins[PIN_SEL_BIT];
	assign serial_rom_clock = loader_busy ? loader_clk : rom_pins[PIN_CLK_BIT];
	assign serial_rom_data_io_out = loader_busy ? loader_dout : rom_pins[PIN_DOUT_BIT];
	assign serial_rom_data_io_oe_n_out = loader_busy ? !loader_drive :
		!rom_pins[PIN_DRIVE_BIT];

	// status and read data
	always_comb begin
		status_value = '0;
		status_value[ST_DEV_READY] = !loader_busy && power_state == POWER_STATE_FULL &&
			!loopback_switching_in;
		status_value[ST_READ_READY] = read_ready;
		status_value[ST_XFER_DONE] = transfer_done_flag;
		status_value[ST_BIG_ENDIAN] = byte_order != '0;
	end

	always_comb begin
		next_rdata = '0;
		if (addr == OFF_DATA_PORT || addr == OFF_DATA_PORT_HI) begin
			next_rdata = word_width_select ? remote_data_in : {8'h00, remote_data_in[7:0]};
		end else if (reg_hit(addr, page, OFF_COMMAND, PAGE0)) begin
			next_rdata[7:0] = {page, dma_cmd, 3'h0};
		end else if (reg_hit(addr, page, OFF_WAKE_STATUS, PAGE3)) begin
			next_rdata[2:0] = wake_flags;
		end else if (reg_hit(addr, page, OFF_POWER, PAGE3)) begin
			next_rdata[1:0] = power_state;
		end else if (reg_hit(addr, page, OFF_RELOAD, PAGE3)) begin
			next_rdata[0] = loader_busy;
		end else if (reg_hit(addr, page, OFF_TIMER_EN, PAGE3)) begin
			next_rdata[0] = timer_enable;
		end else if (reg_hit(addr, page, OFF_TIMER_LOW, PAGE3)) begin
			next_rdata[7:0] = periodic_countdown[7:0];
		end else if (reg_hit(addr, page, OFF_TIMER_HIGH, PAGE3)) begin
			next_rdata[7:0] = periodic_countdown[15:8];
		end else if (reg_hit(addr, page, OFF_ROM_PINS, PAGE0)) begin
			next_rdata[4:0] = {rom_din, rom_pins};
		end else if (reg_hit(addr, page, OFF_PIN_CONFIG, PAGE0)) begin
			next_rdata[2:0] = pin_cfg;
		end else if (reg_hit(addr, page, OFF_STATUS, PAGE0)) begin
			next_rdata[7:0] = status_value;
		end else if (reg_hit(addr, page, OFF_BYTE_ORDER, PAGE0)) begin
			next_rdata[7:0] = byte_order;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			host_data_out <= '0;
			host_data_oe_n_out <= 1'b1;
		end else begin
			host_data_oe_n_out <= cs_n || rd_n;
			if (rd_edge) begin
				host_data_out <= next_rdata;
			end
		end
	end
endmodule // power_wake_status_ctrl

// >>> include/power_wake_pkg.sv
// Purpose: shared constants and types for the housekeeping block.
// Assumes: 100 MHz system clock, 5-bit host register address.
// Notes: register offsets, fields, timings and carriers live here.
package power_wake_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_US = 100;
	localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	localparam int PULSE_MS = 60;
	localparam int PULSE_CYCLES = CLK_HZ / 1000 * PULSE_MS;
	localparam int READ_READY_NS = 60;
	localparam int READ_READY_CYCLES = READ_READY_NS / (1_000_000_000 / CLK_HZ);
	localparam int ROM_HALF_CYCLES = 50;
	localparam int ROM_WORDS = 16;
	localparam int ROM_MIRROR_WORDS = 8;
	localparam int ROM_CMD_BITS = 9;
	localparam int ROM_DUMMY_BIT = 9;
	localparam int ROM_LAST_BIT = 25;
	localparam logic [2:0] ROM_READ_OP = 3'h6;
	localparam logic [15:0] MEM_BASE_LOW = 16'h0000;
	localparam logic [15:0] MEM_BASE_HIGH = 16'h0400;
	localparam logic [4:0] OFF_COMMAND = 5'h00;
	localparam logic [4:0] OFF_PAGED_LAST = 5'h0f;
	localparam logic [4:0] OFF_INT_STATUS = 5'h07;
	localparam logic [4:0] OFF_WAKE_STATUS = 5'h0a;
	localparam logic [4:0] OFF_COUNT_LOW = 5'h0a;
	localparam logic [4:0] OFF_POWER = 5'h0b;
	localparam logic [4:0] OFF_COUNT_HIGH = 5'h0b;
	localparam logic [4:0] OFF_RELOAD = 5'h0c;
	localparam logic [4:0] OFF_TIMER_EN = 5'h0d;
	localparam logic [4:0] OFF_DATA_CONFIG = 5'h0e;
	localparam logic [4:0] OFF_TIMER_LOW = 5'h0e;
	localparam logic [4:0] OFF_TIMER_HIGH = 5'h0f;
	localparam logic [4:0] OFF_DATA_PORT = 5'h10;
	localparam logic [4:0] OFF_DATA_PORT_HI = 5'h11;
	localparam logic [4:0] OFF_ROM_PINS = 5'h14;
	localparam logic [4:0] OFF_PIN_CONFIG = 5'h15;
	localparam logic [4:0] OFF_STATUS = 5'h17;
	localparam logic [4:0] OFF_BYTE_ORDER = 5'h1e;
	localparam logic [4:0] OFF_HOST_RESUME = 5'h1f;
	localparam logic [1:0] PAGE0 = 2'h0;
	localparam logic [1:0] PAGE3 = 2'h3;
	localparam int CR_PAGE_LSB = 6;
	localparam int CR_CMD_LSB = 3;
	localparam logic [2:0] CMD_REMOTE_READ = 3'h1;
	localparam logic [2:0] CMD_REMOTE_WRITE = 3'h2;
	localparam logic [1:0] POWER_STATE_FULL = 2'h0;
	localparam logic [1:0] POWER_STATE_WAKE_LISTEN = 2'h1;
	localparam logic [1:0] POWER_STATE_DEEP_OFF = 2'h2;
	localparam int CFG_PULSE_BIT = 0;
	localparam int CFG_OPEN_DRAIN_BIT = 1;
	localparam int CFG_ACTIVE_HIGH_BIT = 2;
	localparam int PIN_SEL_BIT = 0;
	localparam int PIN_CLK_BIT = 1;
	localparam int PIN_DOUT_BIT = 2;
	localparam int PIN_DRIVE_BIT = 3;
	localparam int PIN_DIN_BIT = 4;
	localparam int ST_DEV_READY = 4;
	localparam int ST_READ_READY = 5;
	localparam int ST_XFER_DONE = 6;
	localparam int ST_BIG_ENDIAN = 7;
	localparam logic [15:0] COUNT_RESET = 16'hffff;
	typedef enum logic [1:0] {LD_IDLE, LD_XFER, LD_GAP} loader_state_e;
	typedef struct packed {
		logic valid;
		logic [15:0] addr;
		logic [15:0] data;
	} mem_write_s;
	typedef struct packed {
		logic core_clk;
		logic mac_host;
		logic rx_path;
		logic phy;
	} power_enables_s;
	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} port_write_s;
endpackage

// >>> rtl/serial_rom_loader.sv
// Purpose: reads the serial rom word by word and writes it to buffer memory.
// Assumes: rom data input already synchronised; 16-bit word organisation.
// Notes: a rom that does not drive the zero dummy bit is treated as absent.
module serial_rom_loader import power_wake_pkg::*; #(
	parameter int HALF_CYCLES_P = ROM_HALF_CYCLES,
	parameter int WORDS_P = ROM_WORDS
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic start_in,
	input wire logic rom_data_in,
	output logic busy_out,
	output logic rom_select_out,
	output logic rom_clock_out,
	output logic rom_data_out,
	output logic rom_drive_out,
	output mem_write_s mem_write_out
);
	loader_state_e state;
	logic [15:0] div_count;
	logic [4:0] bit_idx;
	logic [5:0] word_idx;
	logic [15:0] shift;
	logic mirror_pending;
	logic div_tick;
	logic [8:0] command;

	assign div_tick = div_count == 16'(HALF_CYCLES_P - 1);
	assign command = {ROM_READ_OP, word_idx};
	assign busy_out = state != LD_IDLE;
	// let the data line go once the last address bit is clocked, before the rom answers
	assign rom_drive_out = state == LD_XFER && (bit_idx < 5'(ROM_CMD_BITS - 1) ||
		(bit_idx == 5'(ROM_CMD_BITS - 1) && !rom_clock_out));

	always_ff @(posedge sys_clk_in) begin
		if (reset_in || state == LD_IDLE || div_tick) begin
			div_count <= '0;
		end else begin
			div_count <= div_count + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			state <= LD_IDLE;
			bit_idx <= '0;
			word_idx <= '0;
			shift <= '0;
			mirror_pending <= 1'b0;
			rom_select_out <= 1'b0;
			rom_clock_out <= 1'b0;
			rom_data_out <= 1'b0;
			mem_write_out <= '0;
		end else begin
			mem_write_out.valid <= 1'b0;
			unique case (state)
				LD_IDLE: begin
					if (start_in) begin
						state <= LD_XFER;
						word_idx <= '0;
						bit_idx <= '0;
						rom_select_out <= 1'b1;
						rom_data_out <= command[ROM_CMD_BITS - 1];
					end
				end
				LD_XFER: begin
					if (div_tick && !rom_clock_out) begin
						rom_clock_out <= 1'b1;
						if (bit_idx == 5'(ROM_DUMMY_BIT) && rom_data_in) begin
							state <= LD_IDLE;
							rom_select_out <= 1'b0;
							rom_clock_out <= 1'b0;
						end else if (bit_idx > 5'(ROM_DUMMY_BIT)) begin
							shift <= {shift[14:0], rom_data_in};
						end
					end else if (div_tick) begin
						rom_clock_out <= 1'b0;
						bit_idx <= bit_idx + 5'h01;
						rom_data_out <= (bit_idx < 5'(ROM_CMD_BITS - 1)) ?
							command[4'(ROM_CMD_BITS - 2) - 4'(bit_idx)] : 1'b0;
						if (bit_idx == 5'(ROM_LAST_BIT)) begin
							state <= LD_GAP;
							rom_select_out <= 1'b0;
							mem_write_out <= '{1'b1, MEM_BASE_LOW + {9'h000, word_idx, 1'b0},
								shift};
							mirror_pending <= word_idx < 6'(ROM_MIRROR_WORDS);
						end
					end
				end
				LD_GAP: begin
					if (mirror_pending) begin
						mirror_pending <= 1'b0;
						mem_write_out <= '{1'b1, MEM_BASE_HIGH + {9'h000, word_idx, 1'b0},
							shift};
					end else if (div_tick) begin
						bit_idx <= '0;
						if (word_idx == 6'(WORDS_P - 1)) begin
							state <= LD_IDLE;
						end else begin
							state <= LD_XFER;
							word_idx <= word_idx + 6'h01;
							rom_select_out <= 1'b1;
							rom_data_out <= command[ROM_CMD_BITS - 1];
						end
					end
				end
			endcase
		end
	end
endmodule // serial_rom_loader

// >>> verification/power_wake_status_ctrl_props.sv
// Purpose: port assertions for power_wake_status_ctrl.
// Assumes: one clock, synchronous active-high reset.
// Notes: bound from the bench top file.
module power_wake_status_ctrl_props import power_wake_pkg::*; (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic host_cs_n_in,
	input wire logic host_rd_n_in,
	input wire logic host_data_oe_n_out,
	input wire logic remote_read_start_out,
	input wire logic timer_irq_out,
	input wire mem_write_s mem_write_out,
	input wire power_enables_s power_enables_out,
	input wire logic wake_indicator_out,
	input wire logic wake_indicator_oe_n_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (reset_in);
	property p_irq_hold;
		(timer_irq_out && host_rd_n_in) [*5] |=> timer_irq_out;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
	property p_mirror;
		mem_write_out.valid && mem_write_out.addr < 16'h0010 |=> mem_write_out.valid &&
			mem_write_out.addr == 16'h0400 + $past(mem_write_out.addr);
	endproperty
	a_mirror: assert property (p_mirror) else $error("bad mirror");
	property p_listen;
		power_enables_out.core_clk && !power_enables_out.mac_host |-> power_enables_out.rx_path;
	endproperty
	a_listen: assert property (p_listen) else $error("bad listen");
	property p_deep;
		!power_enables_out.core_clk |-> power_enables_out == 4'h0;
	endproperty
	a_deep: assert property (p_deep) else $error("bad deep");
	property p_phy;
		power_enables_out.phy == power_enables_out.core_clk;
	endproperty
	a_phy: assert property (p_phy) else $error("phy mismatch");
	property p_odrain;
		wake_indicator_oe_n_out |-> !wake_indicator_out;
	endproperty
	a_odrain: assert property (p_odrain) else $error("bad release");
	property p_rd_oe;
		!host_data_oe_n_out |-> $past(!host_cs_n_in && !host_rd_n_in, 3);
	endproperty
	a_rd_oe: assert property (p_rd_oe) else $error("bad oe");
	property p_rr_pulse;
		remote_read_start_out |=> !remote_read_start_out;
	endproperty
	a_rr_pulse: assert property (p_rr_pulse) else $error("long pulse");
endmodule // power_wake_status_ctrl_props

// >>> verification/serial_rom_model.sv
// Purpose: word-wide serial rom answering read commands.
// Assumes: word at address a is a5h, zero, a.
// Notes: output flips when deselected.
module serial_rom_model (
	input wire logic sel_in,
	input wire logic clk_in,
	input wire logic din_in,
	output logic dout_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int n = 0;
	logic [5:0] a;
	wire logic [15:0] w = {8'ha5, 2'h0, a};
	always @(posedge clk_in or negedge sel_in) begin
		if (!sel_in) begin
			n <= 0;
			dout_out <= ~dout_out;
		end else begin
			n <= n + 1;
			if (n >= 3 && n < 9) a <= {a[4:0], din_in};
			if (n == 8) dout_out <= 1'b0;
			if (n >= 9 && n < 25) dout_out <= w[24 - n];
		end
	end
endmodule // serial_rom_model

// >>> verification/power_wake_status_ctrl_tb.sv
// Purpose: self-checking bench for power_wake_status_ctrl.
// Assumes: shortened tick, pulse and rom half period.
// Notes: host pins change at falling edges.
module power_wake_status_ctrl_tb import power_wake_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk_in, reset_in, host_cs_n_in, host_rd_n_in, host_wr_n_in, rom_q;
	logic loopback_switching_in, remote_data_valid_in, remote_read_start_out;
	logic [4:0] host_addr_in;
	logic [15:0] host_data_in, host_data_out, remote_data_in, q, rw;
	logic [2:0] wake_event_in;
	logic host_data_oe_n_out, timer_irq_out, wake_indicator_out, wake_indicator_oe_n_out;
	logic serial_rom_select, serial_rom_clock, serial_rom_data_io_out, serial_rom_data_io_oe_n_out;
	port_write_s remote_write_out;
	mem_write_s mem_write_out;
	power_enables_s power_enables_out;
	int n_mismatch = 0, comparisons = 0, nw = 0, k;
	wire logic serial_rom_data_io_in = serial_rom_data_io_oe_n_out ? rom_q : serial_rom_data_io_out;
	power_wake_status_ctrl #(.TICK_CYCLES_P(10), .PULSE_CYCLES_P(20), .ROM_HALF_CYCLES_P(2))
		i_dut (.*);
	serial_rom_model i_rom (.sel_in(serial_rom_select), .clk_in(serial_rom_clock),
		.din_in(serial_rom_data_io_out), .dout_out(rom_q));
	initial begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge sys_clk_in);
		host_cs_n_in = 1'b0;
		host_addr_in = a;
		host_data_in = {8'h00, d};
		host_wr_n_in = 1'b0;
		repeat (4) @(negedge sys_clk_in);
		host_wr_n_in = 1'b1;
		repeat (4) @(negedge sys_clk_in);
		host_cs_n_in = 1'b1;
	endtask
	task automatic rc(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
		@(negedge sys_clk_in);
		host_cs_n_in = 1'b0;
		host_addr_in = a;
		host_rd_n_in = 1'b0;
		repeat (5) @(negedge sys_clk_in);
		q = host_data_out;
		host_rd_n_in = 1'b1;
		repeat (4) @(negedge sys_clk_in);
		host_cs_n_in = 1'b1;
		chk(q & m, e);
	endtask
	task automatic wait_rdy;
		for (k = 0; k < 400 && q[ST_DEV_READY] !== 1'b1; k++) rc(OFF_STATUS, 16'h0, 16'h0);
		comparisons -= k;
		chk({15'h0, q[ST_DEV_READY]}, 16'h0001);
	endtask
	task automatic wirq;
		for (k = 0; k < 100 && timer_irq_out !== 1'b1; k++) @(negedge sys_clk_in);
		chk({15'h0, timer_irq_out}, 16'h0001);
	endtask
	task automatic wake;
		wake_event_in = 3'h2;
		repeat (3) @(negedge sys_clk_in);
		wake_event_in = 3'h0;
	endtask
	task automatic end_sim;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge sys_clk_in) begin
		if (remote_write_out.valid) rw <= remote_write_out.data;
		if (mem_write_out.valid) begin
			nw <= nw + 1;
			chk(mem_write_out.data, {8'ha5, 4'h0, mem_write_out.addr[4:1]});
			chk(mem_write_out.addr & 16'hfbe1, 16'h0000);
		end
	end
	initial begin
		repeat (30000) @(posedge sys_clk_in);
		n_mismatch++;
		end_sim;
	end
	initial begin
		{host_cs_n_in, host_rd_n_in, host_wr_n_in, reset_in} = 4'hf;
		{host_addr_in, host_data_in, wake_event_in, loopback_switching_in} = '0;
		remote_data_valid_in = 1'b1;
		remote_data_in = 16'h1234;
		repeat (4) @(negedge sys_clk_in);
		reset_in = 1'b0;
		rc(OFF_STATUS, 16'h00d0, 16'h0040);
		wait_rdy;
		chk(16'(nw), 16'd24);
		$display("test autoload done");
		wr(OFF_COMMAND, {PAGE3, 6'h00});
		rc(OFF_TIMER_LOW, 16'h00ff, 16'h00ff);
		rc(OFF_TIMER_HIGH, 16'h00ff, 16'h00ff);
		wr(OFF_TIMER_LOW, 8'h03);
		wr(OFF_TIMER_HIGH, 8'h00);
		wr(OFF_TIMER_EN, 8'h01);
		wirq;
		wr(OFF_COMMAND, {PAGE0, 6'h00});
		rc(OFF_INT_STATUS, 16'h0, 16'h0);
		chk({15'h0, timer_irq_out}, 16'h0000);
		wirq;
		wr(OFF_COMMAND, {PAGE3, 6'h00});
		wr(OFF_TIMER_EN, 8'h00);
		$display("test timer done");
		wr(OFF_POWER, 8'h01);
		chk({12'h0, power_enables_out}, 16'h000b);
		wake;
		chk({12'h0, power_enables_out}, 16'h000f);
		chk({14'h0, wake_indicator_oe_n_out, wake_indicator_out}, 16'h0);
		rc(OFF_WAKE_STATUS, 16'h0007, 16'h0002);
		wr(OFF_WAKE_STATUS, 8'h02);
		chk({14'h0, wake_indicator_oe_n_out, wake_indicator_out}, 16'h1);
		wr(OFF_PIN_CONFIG, 8'h07);
		wr(OFF_POWER, 8'h01);
		wake;
		chk({15'h0, wake_indicator_oe_n_out}, 16'h0001);
		repeat (30) @(negedge sys_clk_in);
		chk({15'h0, wake_indicator_oe_n_out}, 16'h0000);
		wr(OFF_POWER, 8'h02);
		chk({12'h0, power_enables_out}, 16'h0000);
		wr(OFF_HOST_RESUME, 8'h00);
		chk({12'h0, power_enables_out}, 16'h000f);
		$display("test power done");
		wr(OFF_COMMAND, {PAGE0, 6'h00});
		wr(OFF_COUNT_LOW, 8'h02);
		wr(OFF_COUNT_HIGH, 8'h00);
		wr(OFF_COMMAND, 8'h08);
		rc(OFF_STATUS, 16'h0060, 16'h0020);
		rc(OFF_DATA_PORT, 16'hffff, 16'h0034);
		rc(OFF_STATUS, 16'h0040, 16'h0000);
		rc(OFF_DATA_PORT, 16'h0, 16'h0);
		rc(OFF_STATUS, 16'h0040, 16'h0040);
		wr(OFF_DATA_CONFIG, 8'h01);
		rc(OFF_DATA_PORT, 16'hffff, 16'h1234);
		wr(OFF_COMMAND, 8'h10);
		wr(OFF_DATA_PORT, 8'h5a);
		chk(rw, 16'h005a);
		loopback_switching_in = 1'b1;
		rc(OFF_STATUS, 16'h0010, 16'h0000);
		loopback_switching_in = 1'b0;
		wr(OFF_BYTE_ORDER, 8'h01);
		rc(OFF_STATUS, 16'h0090, 16'h0090);
		rc(5'h12, 16'hffff, 16'h0000);
		wr(OFF_COMMAND, 8'h40);
		rc(OFF_POWER, 16'hffff, 16'h0000);
		wr(OFF_POWER, 8'h02);
		chk({12'h0, power_enables_out}, 16'h000f);
		$display("test status done");
		wr(OFF_COMMAND, {PAGE3, 6'h00});
		nw = 0;
		wr(OFF_RELOAD, 8'h01);
		rc(OFF_STATUS, 16'h0010, 16'h0000);
		wait_rdy;
		chk(16'(nw), 16'd24);
		wr(OFF_ROM_PINS, 8'h03);
		chk({13'h0, serial_rom_select, serial_rom_clock, serial_rom_data_io_oe_n_out}, 16'h7);
		$display("test reload done");
		end_sim;
	end
endmodule // power_wake_status_ctrl_tb
bind power_wake_status_ctrl power_wake_status_ctrl_props i_props (.*);
